// ---- sad_consts.vh ----
/*
 sync activity detect: register offsets, field positions, reset values
 and timing counts. assumes a 50 MHz clock and a 32-bit apb slave.
*/
`ifndef SAD_CONSTS_VH
`define SAD_CONSTS_VH

// register word indices and byte addresses (word index times four)
`define SAD_IDX_ACT      8'h01
`define SAD_IDX_POL      8'h02
`define SAD_IDX_SLICER   8'h04
`define SAD_IDX_INCFG    8'h05
`define SAD_IDX_OUTCFG   8'h18
`define SAD_IDX_HSWIDTH  8'h19
`define SAD_ADDR_ACT     12'h004
`define SAD_ADDR_POL     12'h008
`define SAD_ADDR_SLICER  12'h010
`define SAD_ADDR_INCFG   12'h014
`define SAD_ADDR_OUTCFG  12'h060
`define SAD_ADDR_HSWIDTH 12'h064
`define SAD_ADDR_LINELEN 12'h100

// activity status fields
`define SAD_ACT_HS0      0
`define SAD_ACT_VS0      1
`define SAD_ACT_GS0      2
`define SAD_ACT_HS1      3
`define SAD_ACT_VS1      4
`define SAD_ACT_GS1      5
`define SAD_ACT_COMPOSITE_SYNC    6
`define SAD_ACT_TRI      7

// configuration fields
`define SAD_IN_CHAN      0
`define SAD_IN_CSRC_LO   3
`define SAD_IN_CSRC_HI   4
`define SAD_OUT_HPOL     7
`define SAD_OUT_VPOL     6
`define SAD_SLICER_LPF   4

// reset values
`define SAD_SLICER_RST   8'h16
`define SAD_INCFG_RST    8'h00
`define SAD_OUTCFG_RST   8'h00
`define SAD_HSWIDTH_RST  8'h08
`define SAD_LINELEN_RST  12'h320

// timing
`define SAD_GS_RUN       64
`define SAD_VS_PIXEL     7
`define SAD_ACT_TMO_US   100
`define SAD_CLK_MHZ      50
`define SAD_ACT_TMO_CYC  (`SAD_ACT_TMO_US * `SAD_CLK_MHZ)
`define SAD_CS_LONG      12'h0C8

`endif

// ---- sad_sync_detect.v ----
/*
 sync activity and polarity monitor with buffered and retimed sync outputs.
 assumes all sync inputs are already sliced and synchronous to clk_i,
 and that the pixel clock equals clk_i (output data clock is clk_i).
*/
// The implementer's own choice: the APB slave port.
// What this block does
// R01 - monitor six sync inputs, report activity, polarity
// R02 - green activity after 64 matching pulses
// R03 - trilevel flagged without consecutive pulse run
// R04 - composite present on embedded vertical component
// R05 - composite source chosen by config bits 3,4
// R06 - firmware classifies source by priority table
// R07 - firmware confirms composite present after selecting
// R08 - firmware prefers horizontal over green sync
// R09 - green activity valid only without horizontal
// R10 - trilevel valid only green active, horizontal not
// R11 - firmware polls trilevel bit several times
// R12 - firmware keeps green low-pass filter enabled
// R13 - buffered line sync copies selected input
// R14 - green selection passes whole green signal
// R15 - buffered outputs, detectors run in power-down
// R16 - retimed syncs aligned with output data clock
// R17 - retimed line pulse ends pixel 0, width, polarity
// R18 - retimed frame pulse edges at pixel 7
// R19 - status resynchronized into register clock domain
`timescale 1ns/1ps
`include "sad_consts.vh"

module sad_sync_detect
#(
  parameter ACT_TMO = `SAD_ACT_TMO_CYC,
  parameter PER_W   = 16
)
(
  input  wire        clk_i,
  input  wire        srst_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  input  wire [1:0]  line_sync_i,
  input  wire [1:0]  frame_sync_i,
  input  wire [1:0]  green_embedded_sync_input_i,
  input  wire [1:0]  trilevel_i,
  input  wire        power_down_i,
  output reg         buf_line_sync_o,
  output reg         buf_frame_sync_o,
  output reg         retimed_line_sync_out_o,
  output reg         retimed_frame_sync_out_o,
  output reg         green_lpf_en_o
);

  //////////////////////////////////////////////////////////////////////////
  // registers
  reg  [7:0]  slicer_q;
  reg  [7:0]  incfg_q;
  reg  [7:0]  outcfg_q;
  reg  [7:0]  hswidth_q;
  reg  [11:0] linelen_q;
  reg  [7:0]  act_q;
  reg  [7:0]  pol_q;
  wire [7:0]  act_raw;
  wire [7:0]  pol_raw;
  wire        sel_ch;
  wire [1:0]  csrc;
  wire        comp_sync;
  wire        frame_sel;
  wire        wr_en;
  wire [1:0]  hs_act;
  wire [1:0]  vs_act;
  wire [1:0]  gs_act;
  wire [1:0]  hs_pol;
  wire [1:0]  vs_pol;
  wire [1:0]  gs_pol;

  assign sel_ch = incfg_q[`SAD_IN_CHAN];
  assign csrc   = incfg_q[`SAD_IN_CSRC_HI:`SAD_IN_CSRC_LO]; // R05
  assign wr_en  = psel_i & penable_i & pwrite_i & pready_o;

  //////////////////////////////////////////////////////////////////////////
  // per-input activity monitors; never gated by power_down_i
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_ch
      sad_act_mon #(.TMO(ACT_TMO), .RUN(1), .PER_W(PER_W)) u_hs
      (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .sync_i (line_sync_i[g]),
        .act_o  (hs_act[g]),
        .pol_o  (hs_pol[g])
      ); // R01 R15
      sad_act_mon #(.TMO(ACT_TMO), .RUN(1), .PER_W(PER_W)) u_vs
      (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .sync_i (frame_sync_i[g]),
        .act_o  (vs_act[g]),
        .pol_o  (vs_pol[g])
      ); // R01
      sad_act_mon #(.TMO(ACT_TMO), .RUN(`SAD_GS_RUN), .PER_W(PER_W)) u_gs
      (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .sync_i (green_embedded_sync_input_i[g]),
        .act_o  (gs_act[g]),
        .pol_o  (gs_pol[g])
      ); // R02
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // composite source: csrc 01 = composite on line input, 1x = green
  assign comp_sync = csrc[1] ? green_embedded_sync_input_i[sel_ch]
                             : line_sync_i[sel_ch]; // R05

  // composite-present: a long pulse inside the sync stream marks the
  // embedded vertical interval; its recurrence keeps the flag alive
  reg [11:0] cs_len_q;
  reg        cs_pol_q;
  reg [PER_W-1:0] cs_tmo_q;
  reg        cs_present_q;
  reg        cs_vs_q;
  wire       cs_act_lvl;
  wire       cs_long;
  wire       line_pol;

  // polarity of the selected line or green source
  assign line_pol   = pol_raw[csrc[1] ? (sel_ch ? 5 : 2) : (sel_ch ? 3 : 0)];
  assign cs_act_lvl = comp_sync ^ cs_pol_q;
  assign cs_long    = (cs_len_q >= `SAD_CS_LONG);

  // polarity follows the level held most of the time
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      cs_len_q     <= 12'h000;
      cs_pol_q     <= 1'b0;
      cs_tmo_q     <= {PER_W{1'b0}};
      cs_present_q <= 1'b0;
      cs_vs_q      <= 1'b0;
    end
    else
    begin
      cs_pol_q  <= line_pol;
      if (cs_act_lvl && cs_len_q != 12'hFFF)
        cs_len_q <= cs_len_q + 12'h001;
      else if (!cs_act_lvl)
        cs_len_q <= 12'h000;
      cs_vs_q <= cs_act_lvl & cs_long;
      if (cs_long && csrc != 2'b00)
      begin
        cs_present_q <= 1'b1; // R04
        cs_tmo_q     <= {PER_W{1'b0}};
      end
      else if (cs_tmo_q == ACT_TMO[PER_W-1:0] * 2'd2 || csrc == 2'b00)
        cs_present_q <= 1'b0;
      else
        cs_tmo_q <= cs_tmo_q + {{(PER_W-1){1'b0}}, 1'b1};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // trilevel: any single pulse on the trilevel comparator sets the flag
  reg [PER_W-1:0] tri_tmo_q;
  reg             tri_q;
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      tri_tmo_q <= {PER_W{1'b0}};
      tri_q     <= 1'b0;
    end
    else if (trilevel_i[sel_ch])
    begin
      tri_q     <= 1'b1; // R03
      tri_tmo_q <= {PER_W{1'b0}};
    end
    else if (tri_tmo_q == ACT_TMO[PER_W-1:0])
      tri_q <= 1'b0;
    else
      tri_tmo_q <= tri_tmo_q + {{(PER_W-1){1'b0}}, 1'b1};
  end

  //////////////////////////////////////////////////////////////////////////
  // status assembly and resync into the register domain
  assign act_raw = {tri_q, cs_present_q, gs_act[1], vs_act[1], hs_act[1],
                    gs_act[0], vs_act[0], hs_act[0]}; // R01
  assign pol_raw = {2'b00, gs_pol[1], vs_pol[1], hs_pol[1],
                    gs_pol[0], vs_pol[0], hs_pol[0]};

  reg [15:0] st_meta_q;
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      st_meta_q <= 16'h0000;
      act_q     <= 8'h00;
      pol_q     <= 8'h00;
    end
    else
    begin
      st_meta_q <= {act_raw, pol_raw};
      act_q     <= st_meta_q[15:8]; // R19
      pol_q     <= st_meta_q[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // buffered outputs: straight copy of selected input, one flop late; frame carries the extracted pulse when csrc is not 00
  assign frame_sel = (csrc != 2'b00) ? cs_vs_q : frame_sync_i[sel_ch];
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      buf_line_sync_o  <= 1'b0;
      buf_frame_sync_o <= 1'b0;
    end
    else
    begin
      buf_line_sync_o  <= csrc[1] ? green_embedded_sync_input_i[sel_ch]
                                  : line_sync_i[sel_ch]; // R13 R14 R15
      buf_frame_sync_o <= frame_sel; // R15
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // retimed outputs: pixel counter restarts at each line-sync trailing edge
  reg        ls_prev_q;
  reg [11:0] pix_q;
  wire       ls_lvl;
  wire       ls_trail;
  wire       fs_pol;
  wire [11:0] hs_start;
  wire [11:0] pix_d;

  assign ls_lvl   = buf_line_sync_o ^ line_pol;
  assign ls_trail = ls_prev_q & ~ls_lvl;
  assign hs_start = linelen_q - {4'h0, hswidth_q};
  // next pixel index; outputs decode it so edges land on the pixel itself
  assign pix_d    = (ls_trail || pix_q == linelen_q - 12'h001) ?
                    12'h000 : pix_q + 12'h001;
  // extracted frame pulse is already active high
  assign fs_pol   = (csrc != 2'b00) ? 1'b0 : pol_raw[sel_ch ? 4 : 1];

  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ls_prev_q                <= 1'b0;
      pix_q                    <= 12'h000;
      retimed_line_sync_out_o  <= 1'b0;
      retimed_frame_sync_out_o <= 1'b0;
    end
    else
    begin
      ls_prev_q <= ls_lvl;
      pix_q     <= pix_d;
      // active for width pixels before pixel 0, released at pixel 0
      retimed_line_sync_out_o <= outcfg_q[`SAD_OUT_HPOL] ^
        (hswidth_q != 8'h00 && pix_d >= hs_start); // R16 R17
      // frame edges move only at pixel 7, width follows input in lines
      if (pix_d == `SAD_VS_PIXEL)
        retimed_frame_sync_out_o <= outcfg_q[`SAD_OUT_VPOL] ^
          (buf_frame_sync_o ^ fs_pol); // R16 R18
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait state, unmapped reads zero with error
  reg        hit;
  reg [7:0]  rd_v;
  always @*
  begin
    hit  = 1'b1;
    rd_v = 8'h00;
    case (paddr_i)
      `SAD_ADDR_ACT:     rd_v = act_q;
      `SAD_ADDR_POL:     rd_v = pol_q;
      `SAD_ADDR_SLICER:  rd_v = slicer_q;
      `SAD_ADDR_INCFG:   rd_v = incfg_q;
      `SAD_ADDR_OUTCFG:  rd_v = outcfg_q;
      `SAD_ADDR_HSWIDTH: rd_v = hswidth_q;
      `SAD_ADDR_LINELEN: rd_v = 8'h00;
      default:           hit  = 1'b0;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      slicer_q       <= `SAD_SLICER_RST;
      incfg_q        <= `SAD_INCFG_RST;
      outcfg_q       <= `SAD_OUTCFG_RST;
      hswidth_q      <= `SAD_HSWIDTH_RST;
      linelen_q      <= `SAD_LINELEN_RST;
      prdata_o       <= 32'h0000_0000;
      pready_o       <= 1'b0;
      pslverr_o      <= 1'b0;
      green_lpf_en_o <= 1'b0;
    end
    else
    begin
      green_lpf_en_o <= slicer_q[`SAD_SLICER_LPF];
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~hit;
      if (psel_i && !penable_i)
        prdata_o <= (paddr_i == `SAD_ADDR_LINELEN) ? {20'h00000, linelen_q}
                                                    : {24'h000000, rd_v};
      if (wr_en && !pslverr_o)
        case (paddr_i)
          `SAD_ADDR_SLICER:  slicer_q  <= pwdata_i[7:0];
          `SAD_ADDR_INCFG:   incfg_q   <= pwdata_i[7:0]; // R05
          `SAD_ADDR_OUTCFG:  outcfg_q  <= pwdata_i[7:0];
          `SAD_ADDR_HSWIDTH: hswidth_q <= pwdata_i[7:0];
          `SAD_ADDR_LINELEN: linelen_q <= pwdata_i[11:0];
          default:           ;
        endcase
    end
  end

endmodule

//////////////////////////////////////////////////////////////////////////////
// activity and polarity monitor for one sync line
module sad_act_mon
#(
  parameter TMO   = 5000,
  parameter RUN   = 1,
  parameter PER_W = 16
)
(
  input  wire clk_i,
  input  wire srst_i,
  input  wire sync_i,
  output reg  act_o,
  output reg  pol_o
);

  reg             prev_q;
  reg [PER_W-1:0] cnt_q;
  reg [PER_W-1:0] hi_q;
  reg [PER_W-1:0] per_q;
  reg [PER_W-1:0] duty_q;
  reg [PER_W-1:0] idle_q;
  reg [6:0]       run_q;
  reg signed [PER_W:0] bal_q;
  wire rise;

  assign rise = sync_i & ~prev_q;

  // counts matching periods; activity needs RUN of them in a row
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      prev_q <= 1'b0;
      cnt_q  <= {PER_W{1'b0}};
      hi_q   <= {PER_W{1'b0}};
      per_q  <= {PER_W{1'b0}};
      duty_q <= {PER_W{1'b0}};
      idle_q <= {PER_W{1'b0}};
      run_q  <= 7'h00;
      bal_q  <= {(PER_W+1){1'b0}};
      act_o  <= 1'b0;
      pol_o  <= 1'b0;
    end
    else
    begin
      prev_q <= sync_i;
      if (rise)
      begin
        cnt_q  <= {{(PER_W-1){1'b0}}, 1'b1};
        hi_q   <= {{(PER_W-1){1'b0}}, 1'b1};
        per_q  <= cnt_q;
        duty_q <= hi_q;
        idle_q <= {PER_W{1'b0}};
        pol_o  <= ~bal_q[PER_W]; // mostly high means active low
        bal_q  <= {(PER_W+1){1'b0}};
        if (cnt_q == per_q && hi_q == duty_q)
        begin
          if (run_q < RUN[6:0])
            run_q <= run_q + 7'h01;
          if (run_q + 7'h01 >= RUN[6:0])
            act_o <= 1'b1;
        end
        else
          run_q <= 7'h00;
      end
      else
      begin
        cnt_q <= cnt_q + {{(PER_W-1){1'b0}}, 1'b1};
        if (sync_i)
          hi_q <= hi_q + {{(PER_W-1){1'b0}}, 1'b1};
        bal_q <= sync_i ? bal_q + 1'b1 : bal_q - 1'b1;
        if (idle_q == TMO[PER_W-1:0])
        begin
          act_o <= 1'b0;
          run_q <= 7'h00;
        end
        else
          idle_q <= idle_q + {{(PER_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// ---- sad_sync_monitor.sv ----
/*
 checker for the sync monitor: apb answer, error reply, config
 tracking and buffered line and frame sync copy.
 assumes it is bound to every sad_sync_detect instance.
*/
`timescale 1ns/1ps
`include "sad_consts.vh"
module sad_sync_monitor
(
  input wire        clk_i,
  input wire        srst_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire [1:0]  line_sync_i,
  input wire [1:0]  green_embedded_sync_input_i,
  input wire [1:0]  frame_sync_i,
  input wire        buf_frame_sync_o,
  input wire        buf_line_sync_o,
  input wire        green_lpf_en_o
);
  reg       lpf_q;
  reg [4:0] incfg_q;
  reg [1:0] up_q;
  wire      acc = psel_i && penable_i && pready_o;
  wire      hit = paddr_i inside {`SAD_ADDR_ACT, `SAD_ADDR_POL,
    `SAD_ADDR_SLICER, `SAD_ADDR_INCFG, `SAD_ADDR_OUTCFG,
    `SAD_ADDR_HSWIDTH, `SAD_ADDR_LINELEN};
  wire      src = incfg_q[4] ? green_embedded_sync_input_i[incfg_q[0]]
                             : line_sync_i[incfg_q[0]];

  // shadow of written config, cycles since reset
  always @(posedge clk_i)
    if (srst_i)
    begin
      lpf_q   <= 1'h1;
      incfg_q <= 5'h00;
      up_q    <= 2'h0;
    end
    else
    begin
      if (up_q != 2'h3)
        up_q <= up_q + 2'h1;
      if (acc && pwrite_i && paddr_i == `SAD_ADDR_SLICER)
        lpf_q <= pwdata_i[4];
      if (acc && pwrite_i && paddr_i == `SAD_ADDR_INCFG)
        incfg_q <= pwdata_i[4:0];
    end

  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_setup; psel_i && !penable_i; endsequence
  sequence s_access; psel_i && penable_i; endsequence

  //////////////////////////////////////////////////////////////////////////
  a_ready_access: assert property (s_setup ##1 s_access |-> pready_o)
    else $error("no ready in access cycle");
  a_ready_idle: assert property (!(psel_i && penable_i) |-> !pready_o)
    else $error("ready outside access");
  a_err_unmapped: assert property (s_access and !hit |-> pslverr_o)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (s_access and hit |-> !pslverr_o)
    else $error("mapped access refused");
  a_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_err_zero: assert property (s_access and !hit && !pwrite_i
    |-> prdata_o == 32'h00000000) else $error("refused read not zero");
  a_upper_zero: assert property (s_access and !pwrite_i
    |-> prdata_o[31:12] == 20'h00000) else $error("upper bits set");
  a_incfg_back: assert property (s_access and !pwrite_i &&
    paddr_i == `SAD_ADDR_INCFG |-> prdata_o[4:0] == incfg_q)
    else $error("config readback wrong");
  a_lpf_follow: assert property (up_q == 2'h3 && $stable(lpf_q)
    |-> green_lpf_en_o == lpf_q)
    else $error("low-pass enable wrong");
  a_buf_copy: assert property (up_q == 2'h3 && $stable(incfg_q)
    |-> buf_line_sync_o == $past(src)) else $error("buffered sync wrong");
  a_frame_copy: assert property (up_q == 2'h3 && $stable(incfg_q) &&
    incfg_q[4:3] == 2'b00 |-> buf_frame_sync_o ==
    $past(frame_sync_i[incfg_q[0]])) else $error("buffered frame wrong");
endmodule

bind sad_sync_detect sad_sync_monitor u_mon (.clk_i(clk_i),
  .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .line_sync_i(line_sync_i),
  .green_embedded_sync_input_i(green_embedded_sync_input_i),
  .frame_sync_i(frame_sync_i), .buf_frame_sync_o(buf_frame_sync_o),
  .buf_line_sync_o(buf_line_sync_o), .green_lpf_en_o(green_lpf_en_o));

// ---- sad_sync_src.sv ----
/*
 video source model: sliced line, frame, green-embedded and trilevel
 levels for two channels.
 assumes burst is called from just after a clock edge.
*/
`timescale 1ns/1ps
module sad_sync_src
(
  input  wire logic       clk_i,
  output wire logic [1:0] line_o,
  output wire logic [1:0] frame_o,
  output wire logic [1:0] green_o,
  output wire logic [1:0] tri_o
);
  logic [3:0][1:0] lv_q = 8'h00;

  // lines rest at the level last left, no edges between trains
  assign line_o  = lv_q[0];
  assign frame_o = lv_q[1];
  assign green_o = lv_q[2];
  assign tri_o   = lv_q[3];

  // n identical pulses: level v for hi clocks, then ~v for lo
  task automatic burst(input int s, input int c, input int n,
                       input int hi, input int lo, input logic v);
    repeat (n)
    begin
      @(posedge clk_i);
      lv_q[s][c] <= v;
      repeat (hi) @(posedge clk_i);
      lv_q[s][c] <= ~v;
      repeat (lo - 1) @(posedge clk_i);
    end
  endtask
endmodule

// ---- sad_sync_detect_bench.sv ----
/*
 bench for the sync monitor: registers, activity, green run,
 trilevel, composite present, buffered and retimed sync.
 assumes the design, the source model and the bound checker.
*/
`timescale 1ns/1ps
`include "sad_consts.vh"
module sad_sync_detect_bench;
  logic        clk_i   = 1'b0;
  logic        srst_i  = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic        pdown   = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h00000000;
  logic [31:0] rd;
  logic        er;
  wire  [31:0] prdata;
  wire         pready, pslverr, lpf, bl, rls, rfs;
  wire  [1:0]  line, frame, green, trl;
  int          n_fail = 0;
  int          total_checks = 0;

  always #10 clk_i = ~clk_i;

  sad_sync_src src (.clk_i(clk_i), .line_o(line), .frame_o(frame),
    .green_o(green), .tri_o(trl));

  sad_sync_detect #(.ACT_TMO(50)) uut (.clk_i(clk_i), .srst_i(srst_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .line_sync_i(line),
    .frame_sync_i(frame), .green_embedded_sync_input_i(green),
    .trilevel_i(trl), .power_down_i(pdown), .buf_line_sync_o(bl),
    .buf_frame_sync_o(), .retimed_line_sync_out_o(rls),
    .retimed_frame_sync_out_o(rfs), .green_lpf_en_o(lpf));

  //////////////////////////////////////////////////////////////////////////
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      n_fail++;
    end
  endtask

  // one apb transfer, held until pready seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      n_fail++;
      test_done;
    end
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h00000000);
    chk(rd & m, e);
  endtask

  // firmware source decision on channel 0, first match wins
  function automatic logic [1:0] cls(input logic [31:0] v);
    if (v[0] && v[1])
      return 2'h0;
    if (v[0])
      return 2'h1;
    if (v[2])
      return 2'h2;
    return 2'h3;
  endfunction

  task rd_act(input logic [7:0] m, e, input logic [1:0] c);
    rdc(`SAD_ADDR_ACT, {24'h000000, m}, {24'h000000, e});
    chk(cls(rd), c);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task t_regs;
    rdc(`SAD_ADDR_SLICER, 32'hFF, 32'h16);
    rdc(`SAD_ADDR_INCFG, 32'hFF, 32'h00);
    rdc(`SAD_ADDR_HSWIDTH, 32'hFF, 32'h08);
    rdc(12'h0FC, 32'hFFFFFFFF, 32'h00000000);
    chk(er, 1'b1);
    chk(lpf, 1'b1);
    apb(1'b1, `SAD_ADDR_SLICER, 32'h06);
    repeat (2) @(posedge clk_i);
    chk(lpf, 1'b0);
    apb(1'b1, `SAD_ADDR_SLICER, 32'h16);
    apb(1'b1, `SAD_ADDR_OUTCFG, 32'hC0);
    rdc(`SAD_ADDR_OUTCFG, 32'hFF, 32'hC0);
  endtask

  task t_line;
    fork
      src.burst(0, 0, 12, 4, 16, 1'b1);
      src.burst(1, 0, 12, 4, 16, 1'b1);
      src.burst(0, 1, 12, 4, 16, 1'b0);
    join
    rd_act(8'h0B, 8'h0B, 2'h0);
    rdc(`SAD_ADDR_POL, 32'h0B, 32'h08);
    repeat (100) @(posedge clk_i);
    rd_act(8'h3F, 8'h00, 2'h3);
  endtask

  task t_green;
    fork
      src.burst(2, 0, 72, 4, 16, 1'b1);
      begin
        repeat (800) @(posedge clk_i);
        rd_act(8'h04, 8'h00, 2'h3);
      end
    join
    src.burst(3, 0, 1, 2, 2, 1'b1);
    rd_act(8'h87, 8'h84, 2'h2);
    rd_act(8'h87, 8'h84, 2'h2);
  endtask

  task t_composite_sync;
    apb(1'b1, `SAD_ADDR_INCFG, 32'h08);
    src.burst(0, 0, 1, 250, 8, 1'b1);
    src.burst(0, 0, 4, 2, 8, 1'b1);
    rd_act(8'h43, 8'h41, 2'h1);
  endtask

  // retimed pulses on a 20-pixel line: width and frame length counted
  task t_retime;
    int nl, nf;
    nl = 0;
    nf = 0;
    apb(1'b1, `SAD_ADDR_INCFG, 32'h00);
    apb(1'b1, `SAD_ADDR_LINELEN, 32'h14);
    apb(1'b1, `SAD_ADDR_HSWIDTH, 32'h05);
    fork
      src.burst(0, 0, 8, 4, 16, 1'b1);
      begin
        repeat (40) @(posedge clk_i);
        src.burst(1, 0, 1, 40, 1, 1'b1);
      end
      begin
        repeat (60) @(posedge clk_i);
        repeat (20)
        begin
          @(posedge clk_i);
          nl = nl + (rls === 1'b0);
        end
      end
      repeat (140)
      begin
        @(posedge clk_i);
        nf = nf + (rfs === 1'b0);
      end
    join
    chk(nl, 5);
    chk(nf, 40);
  endtask

  task t_buf;
    logic [7:0] cfg [4] = '{8'h00, 8'h01, 8'h10, 8'h11};
    pdown <= 1'b1;
    foreach (cfg[i])
    begin
      apb(1'b1, `SAD_ADDR_INCFG, {24'h000000, cfg[i]});
      fork
        src.burst(0, 0, 5, 3, 5, 1'b1);
        src.burst(0, 1, 5, 2, 7, 1'b1);
        src.burst(2, 0, 5, 4, 3, 1'b1);
        src.burst(2, 1, 5, 5, 6, 1'b1);
      join
    end
    rd_act(8'h0B, 8'h09, 2'h1);
    pdown <= 1'b0;
  endtask

  initial
  begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    t_regs;
    t_line;
    t_green;
    t_composite_sync;
    t_buf;
    t_retime;
    test_done;
  end
endmodule
